// *** logic/dma_crc_engine.sv ***
// Checksum engine that rides on one DMA channel, with an APB register slave
`timescale 1ns/10ps
`default_nettype none
module dma_crc_engine
   import crc_engine_pkg::*;
(
   input  wire logic              CLK_I,
   input  wire logic              RESET_N_I,
   // APB slave
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [ADDR_W-1:0] PADDR_I,
   input  wire logic [DATA_W-1:0] PWDATA_I,
   input  wire logic [LANES-1:0]  PSTRB_I,
   output logic      [DATA_W-1:0] PRDATA_O,
   output logic                   PREADY_O,
   output logic                   PSLVERR_O,
   // Beats moved by the DMA channels
   input  wire logic              DMA_BEAT_I,
   input  wire logic [CH_W-1:0]   DMA_CH_I,
   input  wire logic [DATA_W-1:0] DMA_ADDR_I,
   input  wire logic [DATA_W-1:0] DMA_DATA_I,
   input  wire logic              DMA_BLOCK_DONE_I,
   input  wire logic [DATA_W-1:0] DMA_DEST_START_I,
   // Destination write issued back to the channel
   output logic                   WR_VALID_O,
   output logic      [DATA_W-1:0] WR_ADDR_O,
   output logic      [DATA_W-1:0] WR_DATA_O,
   output logic                   ENGINE_ATTACHED_O
);

   // ==========================================
   // Register state
   logic [CH_W-1:0]   engine_channel_select;
   logic              checksum_type_select;
   logic              append_mode_bit;
   logic              checksum_engine_enable;
   logic [POLY_LENGTH_FIELD_W-1:0] poly_length_field;
   logic              bit_order_select;
   logic              write_reorder_select;
   byte_order_t       byte_order_field;
   logic [DATA_W-1:0] feedback_tap_mask;
   logic [DATA_W-1:0] accum;
   logic [DATA_W-1:0] prdata;
   logic              wr_valid;
   logic [DATA_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;

   // ==========================================
   // APB decode
   wire logic setup_phase  = PSEL_I & ~PENABLE_I;
   wire logic access_phase = PSEL_I & PENABLE_I;
   // Reads are captured in the setup cycle, one cycle before the master samples
   wire logic rd_setup     = setup_phase & ~PWRITE_I;
   wire logic hit_control  = (PADDR_I == OFS_CONTROL);
   wire logic hit_result   = (PADDR_I == OFS_RESULT);
   wire logic hit_tap      = (PADDR_I == OFS_TAP);
   wire logic addr_hit     = hit_control | hit_result | hit_tap;
   wire logic wr_fire      = access_phase & PWRITE_I & addr_hit;
   wire logic wr_control   = wr_fire & hit_control;
   wire logic wr_result    = wr_fire & hit_result;
   wire logic wr_tap       = wr_fire & hit_tap;

   // Zero wait states; unmapped addresses answer with an error
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = access_phase & ~addr_hit;

   // ==========================================
   // Byte lane mask
   localparam int BYTE_W = DATA_W / LANES;

   // Strobe-low lanes keep their old bytes
   logic [DATA_W-1:0] lane_mask;
   genvar gl;
   generate
      for (gl = 0; gl < LANES; gl++) begin : g_lane
         assign lane_mask[gl*BYTE_W +: BYTE_W] = {BYTE_W{PSTRB_I[gl]}};
      end
   endgenerate

   // ==========================================
   // Read views
   // In CRC mode, bits above the programmed length read zero
   logic [DATA_W-1:0] len_mask;
   genvar gb;
   generate
      for (gb = 0; gb < DATA_W; gb++) begin : g_len
         assign len_mask[gb] = (gb <= int'(poly_length_field));
      end
   endgenerate

   // Laid out from the field positions, so reads and writes share one map
   logic [DATA_W-1:0] control_view;
   always_comb begin
      control_view                        = RESET_WORD;
      control_view[BIT_CH_LO +: CH_W]     = engine_channel_select;
      control_view[BIT_TYPE]              = checksum_type_select;
      control_view[BIT_APPEND]            = append_mode_bit;
      control_view[BIT_ENABLE]            = checksum_engine_enable;
      control_view[BIT_POLY_LENGTH_FIELD_LO +: POLY_LENGTH_FIELD_W] = poly_length_field;
      control_view[BIT_BIT_ORDER_SELECT]              = bit_order_select;
      control_view[BIT_WBO]               = write_reorder_select;
      control_view[BIT_BYTE_ORDER_FIELD_LO +: BYTE_ORDER_FIELD_W] = byte_order_field;
   end

   wire logic [DATA_W-1:0] result_view =
      checksum_type_select ? {HALF_ZERO, ~accum[HALF_W-1:0]}
                           : (accum & len_mask);

   wire logic [DATA_W-1:0] read_mux =
      hit_control ? control_view :
      hit_result  ? result_view  :
      hit_tap     ? feedback_tap_mask : RESET_WORD;

   // ==========================================
   // Write data merged with byte strobes
   wire logic [DATA_W-1:0] ctrl_wdata =
      (PWDATA_I & lane_mask) | (control_view & ~lane_mask);
   wire logic [DATA_W-1:0] tap_wdata =
      (PWDATA_I & lane_mask) | (feedback_tap_mask & ~lane_mask);
   wire logic [DATA_W-1:0] seed_wdata =
      (PWDATA_I & lane_mask) | (result_view & ~lane_mask);

   // IP seed is held uncomplemented so the sum can run on it
   wire logic [DATA_W-1:0] seed_store =
      checksum_type_select ? {HALF_ZERO, ~seed_wdata[HALF_W-1:0]}
                           : seed_wdata;

   // Append can only be set while the written reorder stays off
   wire logic new_wbo    = ctrl_wdata[BIT_WBO];
   wire logic new_append = ctrl_wdata[BIT_APPEND] & ~new_wbo;

   // ==========================================
   // Channel attachment
   // Attachment is decided per beat from the channel that carries it
   wire logic ch_match = (DMA_CH_I == engine_channel_select);
   wire logic routed   = checksum_engine_enable & ch_match;
   wire logic beat_use = routed & DMA_BEAT_I;
   wire logic append_done =
      routed & append_mode_bit & DMA_BLOCK_DONE_I;

   assign ENGINE_ATTACHED_O = routed;

   // ==========================================
   // Byte reordering
   // Each output lane picks one source lane, so all four orders cost one small mux per lane
   logic [DATA_W-1:0] reordered;
   genvar go;
   generate
      for (go = 0; go < LANES; go++) begin : g_order
         localparam int SAME_LANE = go;
         localparam int WORD_LANE = LANES - 1 - go;
         localparam int HALF_LANE = go ^ (LANES / 2);
         localparam int PAIR_LANE = go ^ (LANES / 4);
         wire logic [BYTE_W-1:0] from_same = DMA_DATA_I[SAME_LANE*BYTE_W +: BYTE_W];
         wire logic [BYTE_W-1:0] from_word = DMA_DATA_I[WORD_LANE*BYTE_W +: BYTE_W];
         wire logic [BYTE_W-1:0] from_half = DMA_DATA_I[HALF_LANE*BYTE_W +: BYTE_W];
         wire logic [BYTE_W-1:0] from_pair = DMA_DATA_I[PAIR_LANE*BYTE_W +: BYTE_W];
         assign reordered[go*BYTE_W +: BYTE_W] =
            (byte_order_field == ORDER_WORD_REV)      ? from_word :
            (byte_order_field == ORDER_HALF_SWAP)     ? from_half :
            (byte_order_field == ORDER_HALF_BYTE_REV) ? from_pair : from_same;
      end
   endgenerate

   // Written data: reordered only when routed and the select is set
   wire logic [DATA_W-1:0] dest_data =
      (routed & write_reorder_select) ? reordered : DMA_DATA_I;

   // ==========================================
   // Checksum datapath
   logic [DATA_W-1:0] step_out;

   crc_word_step u_step (
      .state_i   (accum),
      .data_i    (reordered),
      .tap_i     (feedback_tap_mask),
      .len_m1_i  (poly_length_field),
      .reflect_i (bit_order_select),
      .ip_mode_i (checksum_type_select),
      .state_o   (step_out)
   );

   // A seed write wins over a beat in the same cycle
   wire logic [DATA_W-1:0] next_accum =
      wr_result ? seed_store :
      beat_use  ? step_out   : accum;

   // ==========================================
   // Destination write request
   wire logic beat_writes = DMA_BEAT_I & ~(routed & append_mode_bit);
   // A foreign beat that meets an append completion is dropped; the channel
   // must keep them in separate cycles
   wire logic next_wr_valid = append_done | beat_writes;
   wire logic [DATA_W-1:0] next_wr_addr =
      append_done ? DMA_DEST_START_I : DMA_ADDR_I;
   // Completion sends the read view, so masked bits go out as zero
   wire logic [DATA_W-1:0] next_wr_data =
      append_done ? result_view : dest_data;

   // ==========================================
   // Control register
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         engine_channel_select  <= '0;
         checksum_type_select   <= 1'b0;
         append_mode_bit        <= 1'b0;
         checksum_engine_enable <= 1'b0;
         poly_length_field      <= '0;
         bit_order_select       <= 1'b0;
         write_reorder_select   <= 1'b0;
         byte_order_field       <= ORDER_NONE;
      end else if (wr_control) begin
         engine_channel_select  <= ctrl_wdata[BIT_CH_LO +: CH_W];
         checksum_type_select   <= ctrl_wdata[BIT_TYPE];
         append_mode_bit        <= new_append;
         checksum_engine_enable <= ctrl_wdata[BIT_ENABLE];
         poly_length_field      <= ctrl_wdata[BIT_POLY_LENGTH_FIELD_LO +: POLY_LENGTH_FIELD_W];
         bit_order_select       <= ctrl_wdata[BIT_BIT_ORDER_SELECT];
         write_reorder_select   <= new_wbo;
         byte_order_field       <= byte_order_t'(ctrl_wdata[BIT_BYTE_ORDER_FIELD_LO +: BYTE_ORDER_FIELD_W]);
      end
   end

   // ==========================================
   // Tap mask
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         feedback_tap_mask <= RESET_WORD;
      end else if (wr_tap) begin
         feedback_tap_mask <= tap_wdata;
      end
   end

   // ==========================================
   // Accumulator
   // Register seeds overwrite the running value; a mode change keeps it
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         accum <= RESET_WORD;
      end else begin
         accum <= next_accum;
      end
   end

   // ==========================================
   // Read data, captured in the setup cycle
   // A read never touches the accumulator
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         prdata <= RESET_WORD;
      end else if (rd_setup) begin
         prdata <= read_mux;
      end
   end

   assign PRDATA_O = prdata;

   // ==========================================
   // Destination write outputs
   // Registered so the channel sees a clean one-cycle request
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         wr_valid <= 1'b0;
         wr_addr  <= RESET_WORD;
         wr_data  <= RESET_WORD;
      end else begin
         wr_valid <= next_wr_valid;
         wr_addr  <= next_wr_addr;
         wr_data  <= next_wr_data;
      end
   end

   assign WR_VALID_O = wr_valid;
   assign WR_ADDR_O  = wr_addr;
   assign WR_DATA_O  = wr_data;

endmodule
`default_nettype wire

// *** logic/crc_engine_pkg.sv ***
// Package with the register map, field layout and types of the DMA checksum engine
package crc_engine_pkg;

   // ==========================================
   // Bus and data widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int HALF_W = 16;
   localparam int LANES  = 4;
   localparam int CH_W   = 3;
   localparam int POLY_LENGTH_FIELD_W = 5;
   localparam int BYTE_ORDER_FIELD_W = 2;

   // ==========================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_RESULT  = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_TAP     = 12'h008;

   // ==========================================
   // Control register field positions
   localparam int BIT_CH_LO   = 0;
   localparam int BIT_TYPE    = 5;
   localparam int BIT_APPEND  = 6;
   localparam int BIT_ENABLE  = 7;
   localparam int BIT_POLY_LENGTH_FIELD_LO = 8;
   localparam int BIT_BIT_ORDER_SELECT    = 24;
   localparam int BIT_WBO     = 27;
   localparam int BIT_BYTE_ORDER_FIELD_LO = 28;

   // ==========================================
   // Reset values
   localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
   localparam logic [HALF_W-1:0] HALF_ZERO  = 16'h0000;

   // Byte reorder choices, in field encoding order
   typedef enum logic [BYTE_ORDER_FIELD_W-1:0] {
      ORDER_NONE,
      ORDER_WORD_REV,
      ORDER_HALF_SWAP,
      ORDER_HALF_BYTE_REV
   } byte_order_t;

endpackage

// *** logic/crc_word_step.sv ***
// One whole data word through the LFSR or the ones-complement checksum
`timescale 1ns/10ps
`default_nettype none
module crc_word_step
   import crc_engine_pkg::*;
(
   input  wire logic [DATA_W-1:0] state_i,
   input  wire logic [DATA_W-1:0] data_i,
   input  wire logic [DATA_W-1:0] tap_i,
   input  wire logic [POLY_LENGTH_FIELD_W-1:0] len_m1_i,
   input  wire logic              reflect_i,
   input  wire logic              ip_mode_i,
   output logic      [DATA_W-1:0] state_o
);

   always_comb begin
      logic [DATA_W-1:0] s;
      logic [DATA_W-1:0] n;
      logic [HALF_W-1:0] h_hi;
      logic [HALF_W-1:0] h_lo;
      logic [HALF_W:0]   sum;
      logic              b;
      logic              fb;
      int                len;
      s    = state_i;
      n    = RESET_WORD;
      h_hi = data_i[DATA_W-1:HALF_W];
      h_lo = data_i[HALF_W-1:0];
      sum  = '0;
      b    = 1'b0;
      fb   = 1'b0;
      len  = int'(len_m1_i);
      if (ip_mode_i) begin
         // Tap mask is not looked at here
         if (reflect_i) begin
            for (int k = 0; k < HALF_W; k++) begin
               h_hi[k] = data_i[DATA_W-1-k];
               h_lo[k] = data_i[HALF_W-1-k];
            end
         end
         // End-around carry cannot overflow twice
         sum = {1'b0, s[HALF_W-1:0]} + {1'b0, h_hi};
         sum = {1'b0, sum[HALF_W-1:0]} + {HALF_ZERO, sum[HALF_W]};
         sum = {1'b0, sum[HALF_W-1:0]} + {1'b0, h_lo};
         sum = {1'b0, sum[HALF_W-1:0]} + {HALF_ZERO, sum[HALF_W]};
         state_o = {HALF_ZERO, sum[HALF_W-1:0]};
      end else begin
         for (int i = 0; i < DATA_W; i++) begin
            b  = reflect_i ? data_i[i] : data_i[DATA_W-1-i];
            fb = b ^ (reflect_i ? s[0] : s[len]);
            for (int j = 0; j < DATA_W; j++) begin
               if (j > len) begin
                  n[j] = 1'b0;
               end else if (reflect_i) begin
                  n[j] = ((j < len) ? s[(j+1) % DATA_W] : 1'b0) ^ (tap_i[j] & fb);
               end else begin
                  n[j] = ((j > 0) ? s[(j+DATA_W-1) % DATA_W] : 1'b0) ^ (tap_i[j] & fb);
               end
            end
            s = n;
         end
         state_o = s;
      end
   end

endmodule
`default_nettype wire

// *** verification/dma_crc_engine_properties.sv ***
// Port-level checks on the DMA checksum engine
`timescale 1ns/10ps
`default_nettype none
module dma_crc_engine_props
   import crc_engine_pkg::*;
(
   input wire logic              CLK_I,
   input wire logic              RESET_N_I,
   input wire logic              PSEL_I,
   input wire logic              PENABLE_I,
   input wire logic              PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [DATA_W-1:0] PRDATA_O,
   input wire logic              PSLVERR_O,
   input wire logic              DMA_BEAT_I,
   input wire logic [DATA_W-1:0] DMA_ADDR_I,
   input wire logic [DATA_W-1:0] DMA_DATA_I,
   input wire logic              DMA_BLOCK_DONE_I,
   input wire logic              WR_VALID_O,
   input wire logic [DATA_W-1:0] WR_ADDR_O,
   input wire logic [DATA_W-1:0] WR_DATA_O,
   input wire logic              ENGINE_ATTACHED_O
);
   // =====
   // Decode
   wire mapped = PADDR_I == OFS_CONTROL || PADDR_I == OFS_RESULT || PADDR_I == OFS_TAP;
   wire rd_acc = PSEL_I & PENABLE_I & ~PWRITE_I;
   wire rd_set = PSEL_I & ~PENABLE_I & ~PWRITE_I;
   // =====
   // Properties
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);
   ctrl_unused_zero_a: assert property (rd_acc && PADDR_I == OFS_CONTROL |-> (PRDATA_O & 32'hC6FF_E018) == 0)
      else $error("reserved control bits set");
   bypass_passes_a: assert property (DMA_BEAT_I && !ENGINE_ATTACHED_O && !DMA_BLOCK_DONE_I |=>
      WR_VALID_O && WR_DATA_O == $past(DMA_DATA_I) && WR_ADDR_O == $past(DMA_ADDR_I)) else $error("bypass lost");
   no_cause_quiet_a: assert property (!DMA_BEAT_I && !DMA_BLOCK_DONE_I |=> !WR_VALID_O)
      else $error("write without cause");
   routed_addr_a: assert property (DMA_BEAT_I && ENGINE_ATTACHED_O && !DMA_BLOCK_DONE_I |=>
      !WR_VALID_O || WR_ADDR_O == $past(DMA_ADDR_I)) else $error("routed beat misaddressed");
   rdata_hold_a: assert property (!rd_set |=> $stable(PRDATA_O))
      else $error("read data moved");
   unmapped_read_a: assert property (rd_acc && !mapped |-> PRDATA_O == 0 && PSLVERR_O)
      else $error("unmapped read not refused");
   mapped_ok_a: assert property (PSEL_I && PENABLE_I && mapped |-> !PSLVERR_O)
      else $error("mapped access refused");
   reset_quiet_a: assert property ($rose(RESET_N_I) |-> !WR_VALID_O && PRDATA_O == 0)
      else $error("outputs busy after reset");
   cover property (DMA_BLOCK_DONE_I && ENGINE_ATTACHED_O ##1 WR_VALID_O);
   cover property (DMA_BEAT_I && ENGINE_ATTACHED_O);
   cover property (PSEL_I && PENABLE_I && PSLVERR_O);
endmodule
bind dma_crc_engine dma_crc_engine_props dma_crc_engine_props_inst (.CLK_I, .RESET_N_I, .PSEL_I, .PENABLE_I,
   .PWRITE_I, .PADDR_I, .PRDATA_O, .PSLVERR_O, .DMA_BEAT_I, .DMA_ADDR_I, .DMA_DATA_I, .DMA_BLOCK_DONE_I,
   .WR_VALID_O, .WR_ADDR_O, .WR_DATA_O, .ENGINE_ATTACHED_O);
`default_nettype wire

// *** verification/dma_beat_source.sv ***
// Behavioural DMA channel handing word beats and block completion to the engine
`timescale 1ns/10ps
`default_nettype none
module dma_beat_source (
   input  wire logic   clk_i,
   output logic        beat_o,
   output logic [2:0]  ch_o,
   output logic [31:0] addr_o,
   output logic [31:0] data_o,
   output logic        done_o,
   output logic [31:0] dest_o
);
   initial begin
      {beat_o, done_o, ch_o, addr_o, data_o, dest_o} = '0;
   end
   // Released address, data and destination lines show the inverse so a stale value never passes for a live one
   task automatic send(input logic [2:0] c, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      beat_o <= 1'b1;
      ch_o   <= c;
      addr_o <= {a[31:2], 2'b00};
      data_o <= d;
      @(posedge clk_i);
      beat_o <= 1'b0;
      addr_o <= ~{a[31:2], 2'b00};
      data_o <= ~d;
   endtask
   task automatic finish_block(input logic [2:0] c, input logic [31:0] s);
      @(posedge clk_i);
      done_o <= 1'b1;
      ch_o   <= c;
      dest_o <= s;
      @(posedge clk_i);
      done_o <= 1'b0;
      dest_o <= ~s;
   endtask
endmodule
`default_nettype wire

// *** verification/tb_dma_crc_engine.sv ***
// Self-checking bench for the DMA checksum engine
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_dma_crc_engine;
   import crc_engine_pkg::*;
   logic              CLK_I = 0, RESET_N_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
   logic [ADDR_W-1:0] PADDR_I = '0;
   logic [DATA_W-1:0] PWDATA_I = '0, PRDATA_O, WR_ADDR_O, WR_DATA_O, DMA_ADDR_I, DMA_DATA_I, DMA_DEST_START_I;
   logic [LANES-1:0]  PSTRB_I = 4'hF;
   logic [CH_W-1:0]   DMA_CH_I;
   logic              PREADY_O, PSLVERR_O, DMA_BEAT_I, DMA_BLOCK_DONE_I, WR_VALID_O, ENGINE_ATTACHED_O;
   int                errors = 0, n_checks = 0;
   logic [DATA_W-1:0] rq[$], acc, ctl, t, d, a;
   logic [63:0]       wq[$], e;
   logic [4:0]        n;
   logic [1:0]        b;
   logic              ip, r;
   dma_crc_engine dma_crc_engine_inst (.*);
   dma_beat_source src (.clk_i(CLK_I), .beat_o(DMA_BEAT_I), .ch_o(DMA_CH_I), .addr_o(DMA_ADDR_I),
      .data_o(DMA_DATA_I), .done_o(DMA_BLOCK_DONE_I), .dest_o(DMA_DEST_START_I));
   always #50 CLK_I = ~CLK_I;
   // =====
   // Bus master and reference
   task automatic apb(input logic w, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd);
      @(posedge CLK_I);
      PSEL_I    <= 1'b1;
      PWRITE_I  <= w;
      PADDR_I   <= ad;
      PWDATA_I  <= wd;
      @(posedge CLK_I);
      PENABLE_I <= 1'b1;
      do @(posedge CLK_I); while (PREADY_O !== 1'b1);
      PSEL_I    <= 1'b0;
      PENABLE_I <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] x);
      rq.push_back(x);
      apb(1'b0, ad, '0);
   endtask
   function automatic logic [DATA_W-1:0] reorder(input logic [DATA_W-1:0] x, input logic [1:0] o);
      case (o)
         2'h1: return {x[7:0], x[15:8], x[23:16], x[31:24]};
         2'h2: return {x[15:0], x[31:16]};
         2'h3: return {x[23:16], x[31:24], x[7:0], x[15:8]};
         default: return x;
      endcase
   endfunction
   function automatic logic [DATA_W-1:0] view();
      return ip ? {16'h0, ~acc[15:0]} : acc & (32'hFFFF_FFFF >> (5'd31 - n));
   endfunction
   function automatic void step(input logic [DATA_W-1:0] x);
      logic        fb;
      logic [16:0] s;
      logic [15:0] h;
      if (ip) begin
         for (int k = 1; k >= 0; k--) begin
            h = x[16*k +: 16];
            if (r) h = {<<{h}};
            s = acc[15:0] + h;
            acc[15:0] = s[15:0] + 16'(s[16]);
         end
      end else begin
         for (int i = 0; i < 32; i++) begin
            fb = x[r ? i : 31 - i] ^ acc[r ? 0 : n];
            acc = r ? ((acc >> 1) & (32'hFFFF_FFFF >> (6'd32 - n))) ^ (t & {32{fb}}) : (acc << 1) ^ (t & {32{fb}});
         end
      end
   endfunction
   // =====
   // Result monitor
   always @(posedge CLK_I) begin
      if (PSEL_I && PENABLE_I && !PWRITE_I) begin
         e = rq.size() ? {32'h0, rq.pop_front()} : 64'hX;
         `CHK(PRDATA_O, e[31:0])
      end
      if (WR_VALID_O === 1'b1) begin
         e = wq.size() ? wq.pop_front() : 64'hX;
         `CHK({WR_ADDR_O, WR_DATA_O}, e)
      end
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge CLK_I);
      RESET_N_I <= 1'b1;
   end
   initial begin
      repeat (20000) @(posedge CLK_I);
      errors++;
      finish_test();
   end
   // =====
   // Tests
   initial begin
      void'($urandom(32'hE25F3F05));
      wait (RESET_N_I === 1'b1);
      apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
      for (int k = 0; k < 4; k++) rd(12'(4 * k), RESET_WORD);
      apb(1'b1, OFS_CONTROL, 32'hFFFF_FFFF);
      rd(OFS_CONTROL, 32'h3900_1FA7);
      apb(1'b1, OFS_CONTROL, 32'h0000_0040);
      rd(OFS_CONTROL, 32'h0000_0040);
      apb(1'b1, OFS_TAP, 32'h1234_5678);
      PSTRB_I <= 4'h5;
      apb(1'b1, OFS_TAP, 32'hFFFF_FFFF);
      PSTRB_I <= 4'hF;
      rd(OFS_TAP, 32'h12FF_56FF);
      $display("register test done");
      for (int i = 0; i < 16; i++) begin
         {ip, r, b} = 4'(i);
         n = 5'($urandom);
         t = $urandom;
         acc = $urandom;
         d = $urandom;
         a = $urandom;
         ctl = (32'(b) << BIT_BYTE_ORDER_FIELD_LO) | (32'(d[0]) << BIT_WBO) | (32'(r) << BIT_BIT_ORDER_SELECT) | (32'(n) << BIT_POLY_LENGTH_FIELD_LO)
               | (32'h1 << BIT_ENABLE) | (32'(ip) << BIT_TYPE) | 32'(a[2:0]);
         apb(1'b1, OFS_TAP, t);
         apb(1'b1, OFS_CONTROL, ctl);
         rd(OFS_CONTROL, ctl);
         rd(OFS_TAP, t);
         apb(1'b1, OFS_RESULT, acc);
         if (ip) acc = {16'h0, ~acc[15:0]};
         rd(OFS_RESULT, view());
         wq.push_back({a[31:2], 2'b00, d[0] ? reorder(d, b) : d});
         src.send(a[2:0], a, d);
         `CHK(ENGINE_ATTACHED_O, 1'b1)
         step(reorder(d, b));
         wq.push_back({~a[31:2], 2'b00, ~d});
         src.send(a[2:0] + 3'h1, ~a, ~d);
         `CHK(ENGINE_ATTACHED_O, 1'b0)
         rd(OFS_RESULT, view());
      end
      $display("checksum test done");
      {ip, r, n} = {2'b00, 5'h1F};
      apb(1'b1, OFS_CONTROL, 32'h0000_1FC5);
      acc = $urandom;
      apb(1'b1, OFS_RESULT, acc);
      repeat (3) begin
         d = $urandom;
         src.send(3'h5, d, d);
         step(d);
      end
      wq.push_back({32'h0000_0100, view()});
      src.finish_block(3'h5, 32'h0000_0100);
      apb(1'b1, OFS_CONTROL, 32'h0000_1F05);
      wq.push_back({32'h0000_0200, d});
      src.send(3'h5, 32'h0000_0200, d);
      `CHK(ENGINE_ATTACHED_O, 1'b0)
      rd(OFS_RESULT, view());
      $display("append and idle test done");
      finish_test();
   end
endmodule
`default_nettype wire
